// >>> include/mctp_regs.svh
// field widths, bit positions and reset values of the timer block
`ifndef MCTP_REGS_SVH
`define MCTP_REGS_SVH
`define MCTP_W 16
`define MCTP_CH0_W 32
`define MCTP_N_CH 10
`define MCTP_N_DC 8
`define MCTP_N_CH1GR 6
`define MCTP_N_ITV 4
`define MCTP_ITV_LSB 10
`define MCTP_CH0_START 0
`define MCTP_DC_CH 10
`define MCTP_PSC_W 4
`define MCTP_DIV_W 3
`define MCTP_CYC_IDX34 3
`define MCTP_CYC_IDX5 1
`define MCTP_NDUTY34 3
`define MCTP_NDUTY5 1
`define MCTP_ZERO16 16'h0000
`define MCTP_ZERO32 32'h0000_0000
`define MCTP_ZERO_PSC 4'h0
`define MCTP_ZERO_DIV 3'h0
`endif

// >>> include/mctp_pkg.sv
// types shared by the timer block
`include "mctp_regs.svh"
package mctp_pkg;
  typedef enum logic [2:0] {
    MCTP_CK_DIV1 = 3'h0,
    MCTP_CK_DIV2 = 3'h1,
    MCTP_CK_DIV4 = 3'h2,
    MCTP_CK_DIV8 = 3'h3,
    MCTP_CK_EXT = 3'h4
  } mctp_second_stage_clock_select_e;
  typedef enum logic [1:0] {
    MCTP_EDGE_RISE = 2'h0,
    MCTP_EDGE_FALL = 2'h1,
    MCTP_EDGE_BOTH = 2'h2
  } mctp_edge_e;
  typedef struct packed {
    logic wr;
    logic [`MCTP_W-1:0] data;
  } mctp_wr_s;
endpackage

// >>> verilog/mctp_clk_stage.sv
// second-stage counter clock select for one channel
`timescale 1ns/1ps
`default_nettype none
`include "mctp_regs.svh"
module mctp_clk_stage (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic firstTick,
  input wire logic extLevel,
  input wire mctp_pkg::mctp_second_stage_clock_select_e clkSel,
  input wire mctp_pkg::mctp_edge_e edgeSel,
  output logic chanTick
);
  logic [`MCTP_DIV_W-1:0] div_q;
  logic extPrev_q;
  logic extRise;
  logic extFall;
  logic extTick;

  assign extRise = extLevel & ~extPrev_q;
  assign extFall = ~extLevel & extPrev_q;
  // edge type only matters on the external source
  assign extTick = (edgeSel == mctp_pkg::MCTP_EDGE_RISE) ? extRise :
                   (edgeSel == mctp_pkg::MCTP_EDGE_FALL) ? extFall :
                   (edgeSel == mctp_pkg::MCTP_EDGE_BOTH) ? extRise | extFall :
                   1'b0;
  assign chanTick =
    (clkSel == mctp_pkg::MCTP_CK_DIV1) ? firstTick :
    (clkSel == mctp_pkg::MCTP_CK_DIV2) ? firstTick & div_q[0] :
    (clkSel == mctp_pkg::MCTP_CK_DIV4) ? firstTick & (&div_q[1:0]) :
    (clkSel == mctp_pkg::MCTP_CK_DIV8) ? firstTick & (&div_q) :
    (clkSel == mctp_pkg::MCTP_CK_EXT) ? extTick :
    1'b0;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= `MCTP_ZERO_DIV;
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= extLevel;
      if (firstTick) begin
        div_q <= div_q + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/mctp_buf_pwm.sv
// buffered-duty pwm channel with its own counter, cleared on the period match
`timescale 1ns/1ps
`default_nettype none
`include "mctp_regs.svh"
module mctp_buf_pwm (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic run,
  input wire mctp_pkg::mctp_wr_s counterWr,
  input wire mctp_pkg::mctp_wr_s dutyWr,
  input wire logic [`MCTP_W-1:0] periodRegister,
  input wire logic [`MCTP_W-1:0] dutyBufferRegister,
  input wire logic irqEnable,
  input wire logic flagClr,
  output logic pwmOut,
  output logic periodFlag,
  output logic periodIrq
);
  logic [`MCTP_W-1:0] cnt_q;
  logic [`MCTP_W-1:0] cnt_d;
  logic [`MCTP_W-1:0] duty_q;
  logic [`MCTP_W-1:0] duty_d;
  logic pwm_d;
  logic flag_q;
  logic step;
  logic cycMatch;
  logic dutyMatch;

  assign step = run & tick;
  assign cycMatch = step & (cnt_q == periodRegister);
  assign dutyMatch = step & (cnt_q == duty_q);
  // a cpu write beats both the clear and the increment
  assign cnt_d = counterWr.wr ? counterWr.data :
                 cycMatch ? `MCTP_ZERO16 :
                 step ? cnt_q + 16'h0001 : cnt_q;
  // duty write racing the buffer transfer merges both values
  assign duty_d = (cycMatch & dutyWr.wr) ? dutyBufferRegister | dutyWr.data :
                  cycMatch ? dutyBufferRegister :
                  dutyWr.wr ? dutyWr.data : duty_q;
  assign pwm_d = (duty_d == `MCTP_ZERO16) ? 1'b0 :
                 cycMatch ? 1'b1 :
                 dutyMatch ? 1'b0 : pwmOut;
  assign periodFlag = flag_q;
  assign periodIrq = flag_q & irqEnable;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= `MCTP_ZERO16;
      duty_q <= `MCTP_ZERO16;
      pwmOut <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      duty_q <= duty_d;
      pwmOut <= pwm_d;
      flag_q <= cycMatch | (flag_q & ~flagClr);
    end
  end
endmodule
`default_nettype wire

// >>> verilog/mctp_timer.sv
// multi-channel timer: one-shot, interval and two pwm styles
`timescale 1ns/1ps
`default_nettype none
`include "mctp_regs.svh"
module mctp_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`MCTP_PSC_W-1:0] firstStagePrescaler,
  input wire mctp_pkg::mctp_second_stage_clock_select_e secondStageClockSelect [`MCTP_N_CH:1],
  input wire mctp_pkg::mctp_edge_e externalEdgeSelect [`MCTP_N_CH:1],
  input wire logic extClkPin,
  input wire logic startWrStb,
  input wire logic [`MCTP_N_CH-1:0] startWrData,
  output logic [`MCTP_N_CH-1:0] counterStartRegister,
  output logic [`MCTP_CH0_W-1:0] freeRunningCounter0,
  input wire logic [`MCTP_N_DC-1:0][`MCTP_W-1:0] matchCaptureRegister,
  input wire logic [`MCTP_N_DC-1:0] downCounterLinkBits,
  input wire logic downStartWrStb,
  input wire logic [`MCTP_N_DC-1:0] downStartWrData,
  input wire mctp_pkg::mctp_wr_s [`MCTP_N_DC-1:0] pulseDownCounterWr,
  input wire logic [`MCTP_N_DC-1:0] downCounterIrqEnable,
  input wire logic [`MCTP_N_DC-1:0] oneshotFlagClr,
  output logic [`MCTP_N_DC-1:0] oneshotOut,
  output logic [`MCTP_N_DC-1:0] oneshotDoneFlag,
  output logic downCounterIrq,
  input wire logic [`MCTP_N_ITV-1:0] intervalIrqEnables,
  input wire logic [`MCTP_N_ITV-1:0] intervalConverterTriggers,
  output logic [`MCTP_N_ITV-1:0] intervalIrq,
  output logic converterTrigger,
  input wire logic [2:0] pwmModeSelects,
  input wire logic [2:0][3:0][`MCTP_W-1:0] pwmGeneralRegister,
  input wire mctp_pkg::mctp_wr_s [6:0] counterWr,
  input wire logic [2:0] cycleFlagClr35,
  output logic [2:0] cycleFlag35,
  output logic [2:0][2:0] pwmOut35,
  output logic [2:0] channelDOutputPin,
  input wire logic [3:0][`MCTP_W-1:0] periodRegister,
  input wire logic [3:0][`MCTP_W-1:0] dutyBufferRegister,
  input wire mctp_pkg::mctp_wr_s [3:0] dutyWr,
  input wire logic [3:0] pwmPeriodIrqEnable,
  input wire logic [3:0] periodFlagClr,
  output logic [3:0] periodFlag,
  output logic [3:0] pwmOut69,
  output logic pwmPeriodIrq
);
  // first-stage prescaler
  logic [`MCTP_PSC_W-1:0] psc_q;
  logic firstTick;
  logic extSync1_q;
  logic extSync2_q;
  logic [`MCTP_N_CH:1] chanTick;
  logic [`MCTP_N_CH-1:0] start_q;
  logic [`MCTP_N_CH-1:0] start_d;

  assign firstTick = (psc_q == firstStagePrescaler);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      psc_q <= `MCTP_ZERO_PSC;
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
    end else begin
      psc_q <= firstTick ? `MCTP_ZERO_PSC : psc_q + 4'h1;
      extSync1_q <= extClkPin;
      extSync2_q <= extSync1_q;
    end
  end

  genvar gc;
  generate
    for (gc = 1; gc <= `MCTP_N_CH; gc = gc + 1) begin : g_clk
      mctp_clk_stage u_stage (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .firstTick(firstTick),
        .extLevel(extSync2_q),
        .clkSel(secondStageClockSelect[gc]),
        .edgeSel(externalEdgeSelect[gc]),
        .chanTick(chanTick[gc])
      );
    end
  endgenerate

  // counter start register
  assign start_d = startWrStb ? startWrData : start_q;
  assign counterStartRegister = start_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= {`MCTP_N_CH{1'b0}};
    end else begin
      start_q <= start_d;
    end
  end

  // channel 0 counter and interval sources
  logic [`MCTP_CH0_W-1:0] cnt0_q;
  logic [`MCTP_N_ITV-1:0] itvPrev_q;
  logic [`MCTP_N_ITV-1:0] itvBits;
  logic [`MCTP_N_ITV-1:0] itvRise;
  logic run0;

  assign run0 = start_q[`MCTP_CH0_START] & firstTick;
  assign itvBits = cnt0_q[`MCTP_ITV_LSB +: `MCTP_N_ITV];
  assign itvRise = itvBits & ~itvPrev_q;
  assign freeRunningCounter0 = cnt0_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt0_q <= `MCTP_ZERO32;
      itvPrev_q <= 4'h0;
      intervalIrq <= 4'h0;
      converterTrigger <= 1'b0;
    end else begin
      if (run0) begin
        cnt0_q <= cnt0_q + 32'h0000_0001;
      end
      itvPrev_q <= itvBits;
      intervalIrq <= itvRise & intervalIrqEnables;
      converterTrigger <= |(itvRise & intervalConverterTriggers);
    end
  end

  // channels 1 and 2: offset counters that launch the down-counters
  logic [`MCTP_W-1:0] cnt1_q;
  logic [`MCTP_W-1:0] cnt2_q;
  logic step1;
  logic step2;
  logic [`MCTP_N_DC-1:0] linkMatch;

  assign step1 = start_q[1] & chanTick[1];
  assign step2 = start_q[2] & chanTick[2];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt1_q <= `MCTP_ZERO16;
      cnt2_q <= `MCTP_ZERO16;
    end else begin
      if (step1) begin
        cnt1_q <= cnt1_q + 16'h0001;
      end
      if (step2) begin
        cnt2_q <= cnt2_q + 16'h0001;
      end
    end
  end

  // down-counters A to H and their one-shot outputs
  logic dcStep;

  assign dcStep = chanTick[`MCTP_DC_CH];
  assign downCounterIrq = |(oneshotDoneFlag & downCounterIrqEnable);

  genvar gd;
  generate
    for (gd = 0; gd < `MCTP_N_DC; gd = gd + 1) begin : g_dc
      logic [`MCTP_W-1:0] dc_q;
      logic [`MCTP_W-1:0] dc_d;
      logic run_q;
      logic run_d;
      logic offMatch;
      logic underflow;
      logic startSet;

      if (gd < `MCTP_N_CH1GR) begin : g_c1
        // offset delay is the channel 1 register value
        assign offMatch = step1 & (cnt1_q == matchCaptureRegister[gd]);
      end else begin : g_c2
        assign offMatch = step2 & (cnt2_q == matchCaptureRegister[gd]);
      end
      assign linkMatch[gd] = offMatch & downCounterLinkBits[gd];
      assign startSet = (downStartWrStb & downStartWrData[gd]) |
                        linkMatch[gd];
      assign underflow = run_q & dcStep & (dc_q == `MCTP_ZERO16);
      // underflow holds zero against a racing cpu write
      assign dc_d = underflow ? `MCTP_ZERO16 :
                    pulseDownCounterWr[gd].wr ? pulseDownCounterWr[gd].data :
                    (run_q & dcStep) ? dc_q - 16'h0001 : dc_q;
      // the underflow clear beats a racing start
      assign run_d = underflow ? 1'b0 : startSet ? 1'b1 : run_q;

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          dc_q <= `MCTP_ZERO16;
          run_q <= 1'b0;
          oneshotOut[gd] <= 1'b0;
          oneshotDoneFlag[gd] <= 1'b0;
        end else begin
          dc_q <= dc_d;
          run_q <= run_d;
          oneshotOut[gd] <= run_d & (dc_d != `MCTP_ZERO16);
          oneshotDoneFlag[gd] <= underflow |
            (oneshotDoneFlag[gd] & ~oneshotFlagClr[gd]);
        end
      end
    end
  endgenerate

  // channels 3 to 5: general-register pwm
  genvar gp;
  genvar gq;
  generate
    for (gp = 0; gp < 3; gp = gp + 1) begin : g_pwm35
      localparam int CycIdx = (gp == 2) ? `MCTP_CYC_IDX5 : `MCTP_CYC_IDX34;
      localparam int NDuty = (gp == 2) ? `MCTP_NDUTY5 : `MCTP_NDUTY34;
      logic [`MCTP_W-1:0] cnt_q;
      logic [`MCTP_W-1:0] cnt_d;
      logic step;
      logic cycMatch;
      logic pwm;
      logic dPin_q;

      assign pwm = pwmModeSelects[gp];
      assign step = start_q[gp+3] & chanTick[gp+3];
      assign cycMatch = step &
        (cnt_q == pwmGeneralRegister[gp][CycIdx]);
      // write wins over clear-on-match and over increment
      assign cnt_d = counterWr[gp].wr ? counterWr[gp].data :
                     (cycMatch & pwm) ? `MCTP_ZERO16 :
                     step ? cnt_q + 16'h0001 : cnt_q;
      assign channelDOutputPin[gp] = pwm ? 1'b0 : dPin_q;

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_q <= `MCTP_ZERO16;
          dPin_q <= 1'b0;
          cycleFlag35[gp] <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          // outside pwm mode the pin toggles on its own match
          if (cycMatch & ~pwm) begin
            dPin_q <= ~dPin_q;
          end
          cycleFlag35[gp] <= cycMatch |
            (cycleFlag35[gp] & ~cycleFlagClr35[gp]);
        end
      end

      for (gq = 0; gq < 3; gq = gq + 1) begin : g_duty
        if (gq < NDuty) begin : g_on
          logic dutyMatch;

          assign dutyMatch = step &
            (cnt_q == pwmGeneralRegister[gp][gq]);

          always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
              pwmOut35[gp][gq] <= 1'b0;
            end else if (!pwm) begin
              pwmOut35[gp][gq] <= 1'b0;
            end else if (cycMatch) begin
              pwmOut35[gp][gq] <= 1'b1;
            end else if (dutyMatch) begin
              pwmOut35[gp][gq] <= 1'b0;
            end
          end
        end else begin : g_off
          assign pwmOut35[gp][gq] = 1'b0;
        end
      end
    end
  endgenerate

  // channels 6 to 9: buffered-duty pwm
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_pwm69
      mctp_buf_pwm u_chan (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(chanTick[gb+6]),
        .run(start_q[gb+6]),
        .counterWr(counterWr[gb+3]),
        .dutyWr(dutyWr[gb]),
        .periodRegister(periodRegister[gb]),
        .dutyBufferRegister(dutyBufferRegister[gb]),
        .irqEnable(pwmPeriodIrqEnable[gb]),
        .flagClr(periodFlagClr[gb]),
        .pwmOut(pwmOut69[gb]),
        .periodFlag(periodFlag[gb]),
        .periodIrq()
      );
    end
  endgenerate

  assign pwmPeriodIrq = |(periodFlag & pwmPeriodIrqEnable);
endmodule
`default_nettype wire

// >>> dv/mctp_timer_props.sv
// concurrent checks on the timer ports
`timescale 1ns/1ps
`default_nettype none
module mctp_timer_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic startWrStb,
  input wire logic [9:0] startWrData,
  input wire logic [9:0] counterStartRegister,
  input wire logic [31:0] freeRunningCounter0,
  input wire logic [7:0] downCounterIrqEnable,
  input wire logic [7:0] oneshotOut,
  input wire logic [7:0] oneshotDoneFlag,
  input wire logic downCounterIrq,
  input wire logic [3:0] intervalIrqEnables,
  input wire logic [3:0] intervalConverterTriggers,
  input wire logic [3:0] intervalIrq,
  input wire logic converterTrigger,
  input wire logic [2:0] pwmModeSelects,
  input wire logic [2:0] channelDOutputPin,
  input wire logic [3:0] pwmPeriodIrqEnable,
  input wire logic [3:0] periodFlag,
  input wire logic pwmPeriodIrq
);
  logic [3:0] prevItv_q;
  logic [3:0] riseItv;
  // interval source bits that went high in this cycle
  assign riseItv = freeRunningCounter0[13:10] & ~prevItv_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) prevItv_q <= 4'h0;
    else prevItv_q <= freeRunningCounter0[13:10];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_START_LOAD: assert property (startWrStb |=>
    counterStartRegister == $past(startWrData))
    else $error("start register missed a write");
  AST_CH0_HOLD: assert property (!counterStartRegister[0] |=>
    $stable(freeRunningCounter0))
    else $error("channel 0 counter moved while stopped");
  AST_ITV_IRQ: assert property (1'b1 |=>
    intervalIrq == $past(riseItv & intervalIrqEnables))
    else $error("interval request wrong");
  AST_ADC_TRIG: assert property (1'b1 |=>
    converterTrigger == $past(|(riseItv & intervalConverterTriggers)))
    else $error("converter trigger wrong");
  AST_D_PIN: assert property (1'b1 |=>
    (channelDOutputPin & pwmModeSelects & $past(pwmModeSelects)) == 3'h0)
    else $error("D pin high in pwm mode");
  AST_DC_IRQ: assert property (
    downCounterIrq == |(oneshotDoneFlag & downCounterIrqEnable))
    else $error("down-counter request wrong");
  AST_PWM_IRQ: assert property (
    pwmPeriodIrq == |(periodFlag & pwmPeriodIrqEnable))
    else $error("period request wrong");
  AST_DONE_OUT: assert property (1'b1 |=>
    (oneshotDoneFlag & ~$past(oneshotDoneFlag) & oneshotOut) == 8'h00)
    else $error("one-shot output high at underflow");
endmodule
bind mctp_timer mctp_timer_props i_mctp_timer_props (.core_clk, .sys_rst,
  .startWrStb, .startWrData, .counterStartRegister, .freeRunningCounter0,
  .downCounterIrqEnable, .oneshotOut, .oneshotDoneFlag, .downCounterIrq,
  .intervalIrqEnables, .intervalConverterTriggers, .intervalIrq,
  .converterTrigger, .pwmModeSelects, .channelDOutputPin,
  .pwmPeriodIrqEnable, .periodFlag, .pwmPeriodIrq);
`default_nettype wire

// >>> dv/mctp_far_side.sv
// far side: external count clock source and converter trigger sink
`timescale 1ns/1ps
`default_nettype none
module mctp_far_side (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic converterTrigger,
  output logic extClkPin,
  output logic [15:0] trigCount
);
  logic [1:0] div_q;
  // free-running count clock, toggles every third core cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 2'h0;
      extClkPin <= 1'b0;
      trigCount <= 16'h0000;
    end else begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) extClkPin <= ~extClkPin;
      if (converterTrigger) trigCount <= trigCount + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> dv/multi_channel_timer_pwm_oneshot_tb_top.sv
// self-checking bench for the multi-channel timer
`timescale 1ns/1ps
`default_nettype none
module multi_channel_timer_pwm_oneshot_tb_top;
  localparam integer W = 3072;
  logic core_clk, sys_rst, extClkPin, startWrStb, downStartWrStb;
  logic downCounterIrq, converterTrigger, pwmPeriodIrq, meas;
  logic [3:0] firstStagePrescaler;
  mctp_pkg::mctp_second_stage_clock_select_e secondStageClockSelect [10:1];
  mctp_pkg::mctp_edge_e externalEdgeSelect [10:1];
  logic [9:0] startWrData, counterStartRegister;
  logic [31:0] freeRunningCounter0;
  logic [7:0][15:0] matchCaptureRegister;
  logic [7:0] downCounterLinkBits, downStartWrData, downCounterIrqEnable;
  logic [7:0] oneshotFlagClr, oneshotOut, oneshotDoneFlag;
  mctp_pkg::mctp_wr_s [7:0] pulseDownCounterWr;
  logic [3:0] intervalIrqEnables, intervalConverterTriggers, intervalIrq;
  logic [2:0] pwmModeSelects, cycleFlagClr35, cycleFlag35, channelDOutputPin;
  logic [2:0][3:0][15:0] pwmGeneralRegister;
  logic [2:0][2:0] pwmOut35;
  mctp_pkg::mctp_wr_s [6:0] counterWr;
  mctp_pkg::mctp_wr_s [3:0] dutyWr;
  logic [3:0][15:0] periodRegister, dutyBufferRegister;
  logic [3:0] pwmPeriodIrqEnable, periodFlagClr, periodFlag, pwmOut69;
  logic [15:0] trigCount;
  integer fails, comparisons, seed, cyc, i, n, e, d;
  integer irqN [4], osHi [8], osAt [8], hi69 [4], hi35 [3][3], wd [8];
  mctp_timer i_mctp_timer (.core_clk, .sys_rst, .firstStagePrescaler,
    .secondStageClockSelect, .externalEdgeSelect, .extClkPin, .startWrStb,
    .startWrData, .counterStartRegister, .freeRunningCounter0,
    .matchCaptureRegister, .downCounterLinkBits, .downStartWrStb,
    .downStartWrData, .pulseDownCounterWr, .downCounterIrqEnable,
    .oneshotFlagClr, .oneshotOut, .oneshotDoneFlag, .downCounterIrq,
    .intervalIrqEnables, .intervalConverterTriggers, .intervalIrq,
    .converterTrigger, .pwmModeSelects, .pwmGeneralRegister, .counterWr,
    .cycleFlagClr35, .cycleFlag35, .pwmOut35, .channelDOutputPin,
    .periodRegister, .dutyBufferRegister, .dutyWr, .pwmPeriodIrqEnable,
    .periodFlagClr, .periodFlag, .pwmOut69, .pwmPeriodIrq);
  mctp_far_side i_mctp_far_side (.core_clk, .sys_rst, .converterTrigger,
    .extClkPin, .trigCount);
  function automatic integer rises(input integer v, b);
    return (v + (1 << b)) >> (b + 1);
  endfunction
  // high cycles within the window for a duty and cycle value
  function automatic integer hiExp(input integer dt, p);
    if (dt == 0) return 0;
    if (dt >= p) return W;
    return W * (dt + 1) / (p + 1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrStart(input logic [9:0] dat);
    startWrData = dat;
    startWrStb = 1'b1;
    @(negedge core_clk);
    startWrStb = 1'b0;
    chk(counterStartRegister, dat);
    // let an edge pass with the strobe low before the next write
    @(negedge core_clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // outputs are tallied on the rising edge, before the design updates
  always @(posedge core_clk) begin
    cyc++;
    for (int a = 0; a < 8; a++) begin
      if (a < 4) irqN[a] += intervalIrq[a];
      if (a < 4 && meas) hi69[a] += pwmOut69[a];
      for (int b = 0; b < 3; b++) begin
        if (a < 3 && meas) hi35[a][b] += pwmOut35[a][b];
      end
      osHi[a] += oneshotOut[a];
      if (oneshotOut[a] && osAt[a] == 0) osAt[a] = cyc;
    end
  end
  initial begin
    #800000;
    fails++;
    close_out;
  end
  initial begin
    seed = 32'hB89AF90C;
    fails = 0;
    comparisons = 0;
    cyc = 0;
    meas = 1'b0;
    irqN = '{default: 0};
    osHi = '{default: 0};
    osAt = '{default: 0};
    hi69 = '{default: 0};
    hi35 = '{default: 0};
    sys_rst = 1'b1;
    firstStagePrescaler = 4'h0;
    for (i = 1; i <= 10; i++) begin
      secondStageClockSelect[i] = mctp_pkg::MCTP_CK_DIV1;
      externalEdgeSelect[i] = mctp_pkg::MCTP_EDGE_RISE;
    end
    {startWrStb, startWrData, downStartWrStb, downStartWrData} = '0;
    {matchCaptureRegister, downCounterLinkBits, downCounterIrqEnable} = '0;
    {oneshotFlagClr, pulseDownCounterWr, intervalIrqEnables} = '0;
    {intervalConverterTriggers, pwmModeSelects, cycleFlagClr35} = '0;
    {pwmGeneralRegister, counterWr, dutyWr, periodRegister} = '0;
    {dutyBufferRegister, pwmPeriodIrqEnable, periodFlagClr} = '0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk(freeRunningCounter0, 0);
    wrStart(10'($random(seed)) & 10'h3F8);
    wrStart(10'h000);
    intervalIrqEnables = 4'($random(seed));
    intervalConverterTriggers = 4'($random(seed));
    wrStart(10'h001);
    repeat (8500) @(negedge core_clk);
    wrStart(10'h000);
    repeat (4) @(negedge core_clk);
    n = 0;
    for (i = 0; i < 4; i++) begin
      e = rises(freeRunningCounter0, 10 + i);
      chk(irqN[i], intervalIrqEnables[i] ? e : 0);
      n += intervalConverterTriggers[i] ? e : 0;
    end
    chk(trigCount, n);
    for (i = 0; i < 8; i++) begin
      matchCaptureRegister[i] = 16'h0020 + 16'($random(seed) & 63);
      wd[i] = 4 + ($random(seed) & 15);
      pulseDownCounterWr[i] = '{1'b1, 16'(wd[i])};
    end
    downCounterLinkBits = 8'($random(seed)) | 8'h01;
    downCounterIrqEnable = 8'($random(seed));
    @(negedge core_clk);
    pulseDownCounterWr = '0;
    wrStart(10'h006);
    repeat (200) @(negedge core_clk);
    for (i = 0; i < 8; i++) begin
      chk(osHi[i], downCounterLinkBits[i] ? wd[i] : 0);
      e = osAt[0] - matchCaptureRegister[0];
      if (downCounterLinkBits[i]) chk(osAt[i] - matchCaptureRegister[i], e);
    end
    chk(oneshotDoneFlag, downCounterLinkBits);
    chk(downCounterIrq, |(downCounterLinkBits & downCounterIrqEnable));
    oneshotFlagClr = 8'hFF;
    @(negedge core_clk);
    oneshotFlagClr = 8'h00;
    chk(oneshotDoneFlag, 0);
    e = ($random(seed) & 255) % 3;
    firstStagePrescaler = 4'((1 << e) - 1);
    pwmModeSelects = 3'h7;
    pwmPeriodIrqEnable = 4'($random(seed));
    for (i = 0; i < 7; i++) begin
      n = (4 << (($random(seed) & 255) % 3)) - 1;
      d = 1 + ($random(seed) & 255) % (n - 1);
      if (i < 3) begin
        secondStageClockSelect[3 + i] = mctp_pkg::mctp_second_stage_clock_select_e'(i + 1);
        for (e = 0; e < 3; e++) pwmGeneralRegister[i][e] = 16'(d + e) % n;
        pwmGeneralRegister[i][0] = 16'(d);
        pwmGeneralRegister[i][(i == 2) ? 1 : 3] = 16'(n);
      end else begin
        secondStageClockSelect[3 + i] = mctp_pkg::MCTP_CK_EXT;
        externalEdgeSelect[3 + i] = mctp_pkg::mctp_edge_e'(i % 3);
        periodRegister[i - 3] = 16'(n);
        e = (i == 4) ? d : (i == 3) ? 0 : n + i - 5;
        dutyBufferRegister[i - 3] = 16'(e);
      end
    end
    wrStart(10'h3F8);
    repeat (1024) @(negedge core_clk);
    meas = 1'b1;
    repeat (W) @(negedge core_clk);
    meas = 1'b0;
    for (i = 0; i < 9; i++) begin
      n = pwmGeneralRegister[i / 3][(i < 6) ? 3 : 1];
      // no zero-duty special case here: a zero duty still gives one high tick
      d = pwmGeneralRegister[i / 3][i % 3];
      e = (i > 6) ? 0 : W * (d + 1) / (n + 1);
      chk(hi35[i / 3][i % 3], e);
    end
    for (i = 0; i < 4; i++) begin
      e = hiExp(dutyBufferRegister[i], periodRegister[i]);
      chk(hi69[i], e);
    end
    chk(channelDOutputPin, 0);
    chk(cycleFlag35, 3'h7);
    chk(periodFlag, 4'hF);
    chk(pwmPeriodIrq, |pwmPeriodIrqEnable);
    wrStart(10'h000);
    cycleFlagClr35 = 3'h7;
    periodFlagClr = 4'hF;
    @(negedge core_clk);
    {cycleFlagClr35, periodFlagClr} = '0;
    chk({cycleFlag35, periodFlag, pwmPeriodIrq}, 0);
    close_out;
  end
endmodule
`default_nettype wire
